// file: nrs_pkg.sv
package nrs_pkg;
  localparam int NRS_NREG = 8;
  localparam int NRS_W = 80;
  // Operation requested by the host in one cycle
  typedef enum logic [2:0] {
    NRS_OP_NOP = 3'h0,
    NRS_OP_PUSH = 3'h1,
    NRS_OP_POP = 3'h2,
    NRS_OP_WRREL = 3'h3,
    NRS_OP_RDREL = 3'h4,
    NRS_OP_ARITH = 3'h5,
    NRS_OP_SQRT = 3'h6,
    NRS_OP_WRRES = 3'h7
  } nrs_op_t;
  // Memory operand formats
  typedef enum logic [2:0] {
    NRS_FMT_EXT = 3'h0,
    NRS_FMT_I16 = 3'h1,
    NRS_FMT_I32 = 3'h2,
    NRS_FMT_I64 = 3'h3,
    NRS_FMT_F32 = 3'h4,
    NRS_FMT_F64 = 3'h5,
    NRS_FMT_BCD = 3'h6
  } nrs_fmt_t;
  localparam logic [1:0] NRS_TAG_VALID = 2'h0;
  localparam logic [1:0] NRS_TAG_ZERO = 2'h1;
  localparam logic [1:0] NRS_TAG_SPECIAL = 2'h2;
  localparam logic [1:0] NRS_TAG_EMPTY = 2'h3;
  localparam logic [16:0] NRS_BIAS_SGL = 17'h0007f;
  localparam logic [16:0] NRS_BIAS_DBL = 17'h003ff;
  localparam logic [16:0] NRS_BIAS_EXT = 17'h03fff;
  localparam logic [14:0] NRS_EMAX_SGL = 15'h00ff;
  localparam logic [14:0] NRS_EMAX_DBL = 15'h07ff;
  localparam logic [14:0] NRS_EMAX_EXT = 15'h7fff;
  localparam int NRS_SW_TOP_LSB = 11;
  localparam int NRS_SW_C1_BIT = 9;
  localparam int NRS_SW_FAULT_BIT = 6;
  localparam logic [2:0] NRS_TOP_RST = 3'h0;
  localparam logic [63:0] NRS_INT_INDEF = 64'h8000000000000000;
  localparam logic [63:0] NRS_BCD_LIMIT = 64'h0de0b6b3a7640000;
  localparam logic [79:0] NRS_BCD_INDEF = 80'hffff0000000000000000;
endpackage : nrs_pkg

// file: nrs_stack.sv
`timescale 1ns/1ps
module nrs_stack import nrs_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire nrs_op_t i_op,
  input wire nrs_fmt_t i_fmt,
  input wire logic [2:0] i_idx,
  input wire logic i_src_mem,
  input wire logic [79:0] i_mem_data,
  input wire logic [79:0] i_res_data,
  input wire logic i_clr_stack_fault,
  output logic [79:0] o_store_data,
  output logic [79:0] o_src_a,
  output logic [79:0] o_src_b,
  output logic [15:0] o_status_word,
  output logic [15:0] o_tag_word,
  output logic o_ack
);

  // ****************************************
  // Conversion functions
  // ****************************************
  // Denormal results are flushed to zero; gradual underflow is not modelled here
  function automatic logic [79:0] norm_ext(input logic s, input logic [63:0] mag, input logic [16:0] e0);
    logic [63:0] m;
    logic signed [16:0] e;
    m = mag;
    e = e0;
    for (int i = 0; i < 63; i++) begin
      if (!m[63]) begin
        m = {m[62:0], 1'b0};
        e = e - 17'sd1;
      end
    end
    if (mag == 64'h0 || e <= 17'sd0) begin
      return {s, 79'h0};
    end
    return {s, e[14:0], m};
  endfunction : norm_ext

  function automatic logic [79:0] int_to_ext(input logic [63:0] v);
    logic [63:0] mag;
    mag = v[63] ? 64'(-v) : v;
    return norm_ext(v[63], mag, 17'(NRS_BIAS_EXT + 17'd63));
  endfunction : int_to_ext

  function automatic logic [79:0] fp_to_ext(input logic s, input logic [14:0] ex, input logic [62:0] fr,
                                            input logic [16:0] bias, input logic [14:0] emax);
    if (ex == emax) begin
      return {s, NRS_EMAX_EXT, 1'b1, fr};
    end
    if (ex == 15'h0) begin
      return norm_ext(s, {1'b0, fr}, 17'(17'd1 - bias + NRS_BIAS_EXT));
    end
    return {s, 15'({2'h0, ex} - bias + NRS_BIAS_EXT), 1'b1, fr};
  endfunction : fp_to_ext

  function automatic logic [79:0] bcd_to_ext(input logic [79:0] d);
    logic [63:0] acc;
    acc = 64'h0;
    for (int i = 17; i >= 0; i--) begin
      acc = 64'(acc * 64'd10 + {60'h0, d[4*i+:4]});
    end
    return norm_ext(d[79], acc, 17'(NRS_BIAS_EXT + 17'd63));
  endfunction : bcd_to_ext

  function automatic logic [79:0] load_conv(input nrs_fmt_t f, input logic [79:0] d);
    case (f)
      NRS_FMT_I16: return int_to_ext({{48{d[15]}}, d[15:0]});
      NRS_FMT_I32: return int_to_ext({{32{d[31]}}, d[31:0]});
      NRS_FMT_I64: return int_to_ext(d[63:0]);
      NRS_FMT_F32: return fp_to_ext(d[31], {7'h0, d[30:23]}, {d[22:0], 40'h0}, NRS_BIAS_SGL, NRS_EMAX_SGL);
      NRS_FMT_F64: return fp_to_ext(d[63], {4'h0, d[62:52]}, {d[51:0], 11'h0}, NRS_BIAS_DBL, NRS_EMAX_DBL);
      NRS_FMT_BCD: return bcd_to_ext(d);
      default: return d;
    endcase
  endfunction : load_conv

  // Truncates toward zero; out-of-range gives the integer indefinite
  function automatic logic [63:0] ext_to_int(input logic [79:0] x);
    logic [16:0] e;
    logic [63:0] mag;
    e = {2'h0, x[78:64]};
    if (e < NRS_BIAS_EXT) begin
      return 64'h0;
    end
    if (e > 17'(NRS_BIAS_EXT + 17'd62)) begin
      return NRS_INT_INDEF;
    end
    mag = x[63:0] >> (6'd63 - 6'(e - NRS_BIAS_EXT));
    return x[79] ? 64'(-mag) : mag;
  endfunction : ext_to_int

  // Result packed as sign, 15-bit exponent, 63-bit chopped fraction
  function automatic logic [78:0] ext_to_fp(input logic [79:0] x, input logic [16:0] bias, input logic [14:0] emax);
    logic signed [16:0] ea;
    ea = $signed({2'h0, x[78:64]}) - $signed(NRS_BIAS_EXT) + $signed(bias);
    if (x[78:64] == NRS_EMAX_EXT) begin
      return {x[79], emax, x[62:0]};
    end
    if (x[78:64] == 15'h0 || ea <= 17'sd0) begin
      return {x[79], 78'h0};
    end
    if (ea >= $signed({2'h0, emax})) begin
      return {x[79], emax, 63'h0};
    end
    return {x[79], ea[14:0], x[62:0]};
  endfunction : ext_to_fp

  function automatic logic [79:0] int_to_bcd(input logic [63:0] v);
    logic [63:0] mag;
    logic [71:0] b;
    mag = v[63] ? 64'(-v) : v;
    b = 72'h0;
    if (mag >= NRS_BCD_LIMIT) begin
      return NRS_BCD_INDEF;
    end
    for (int i = 63; i >= 0; i--) begin
      for (int j = 0; j < 18; j++) begin
        if (b[4*j+:4] >= 4'h5) begin
          b[4*j+:4] = 4'(b[4*j+:4] + 4'h3);
        end
      end
      b = {b[70:0], mag[i]};
    end
    return {v[63], 7'h0, b};
  endfunction : int_to_bcd

  function automatic logic [79:0] store_conv(input nrs_fmt_t f, input logic [79:0] x);
    logic [63:0] v;
    logic [78:0] r;
    v = ext_to_int(x);
    r = ext_to_fp(x, (f == NRS_FMT_F32) ? NRS_BIAS_SGL : NRS_BIAS_DBL,
                  (f == NRS_FMT_F32) ? NRS_EMAX_SGL : NRS_EMAX_DBL);
    case (f)
      NRS_FMT_I16: return {64'h0, (v[63:15] == {49{v[15]}}) ? v[15:0] : NRS_INT_INDEF[63:48]};
      NRS_FMT_I32: return {48'h0, (v[63:31] == {33{v[31]}}) ? v[31:0] : NRS_INT_INDEF[63:32]};
      NRS_FMT_I64: return {16'h0, v};
      NRS_FMT_F32: return {48'h0, r[78], r[70:63], r[62:40]};
      NRS_FMT_F64: return {16'h0, r[78], r[73:63], r[62:11]};
      NRS_FMT_BCD: return int_to_bcd(v);
      default: return x;
    endcase
  endfunction : store_conv

  function automatic logic [1:0] classify(input logic [79:0] x);
    if (x[78:64] == NRS_EMAX_EXT) begin
      return NRS_TAG_SPECIAL;
    end
    if (x[78:64] == 15'h0) begin
      return (x[63:0] == 64'h0) ? NRS_TAG_ZERO : NRS_TAG_SPECIAL;
    end
    return x[63] ? NRS_TAG_VALID : NRS_TAG_SPECIAL;
  endfunction : classify

  // ****************************************
  // Stack state
  // ****************************************
  logic [79:0] regs_r [NRS_NREG];
  logic [79:0] regs_nxt [NRS_NREG];
  logic [1:0] tag_r [NRS_NREG];
  logic [1:0] tag_nxt [NRS_NREG];
  logic [2:0] top_r, top_nxt;
  logic stack_fault_r, stack_fault_nxt, c1_r, c1_nxt, ack_r, ack_nxt;
  logic [79:0] store_r, store_nxt, srca_r, srca_nxt, srcb_r, srcb_nxt;
  logic [79:0] ld_ext;
  logic [2:0] phys, push_idx;

  assign ld_ext = load_conv(i_fmt, i_mem_data);
  assign phys = 3'(top_r + i_idx);
  assign push_idx = 3'(top_r - 3'h1);

  always_comb begin
    regs_nxt = regs_r;
    tag_nxt = tag_r;
    top_nxt = top_r;
    stack_fault_nxt = stack_fault_r & ~i_clr_stack_fault;
    c1_nxt = c1_r;
    store_nxt = store_r;
    srca_nxt = srca_r;
    srcb_nxt = srcb_r;
    ack_nxt = (i_op != NRS_OP_NOP);
    // Faults are applied after the clear, so a fault in the clear cycle still sets the flag
    case (i_op)
      NRS_OP_PUSH: begin
        if (tag_r[push_idx] != NRS_TAG_EMPTY) begin
          stack_fault_nxt = 1'b1;
          c1_nxt = 1'b1;
        end else begin
          top_nxt = push_idx;
          regs_nxt[push_idx] = ld_ext;
          tag_nxt[push_idx] = classify(ld_ext);
        end
      end
      NRS_OP_POP: begin
        if (tag_r[top_r] == NRS_TAG_EMPTY) begin
          stack_fault_nxt = 1'b1;
          c1_nxt = 1'b0;
        end else begin
          store_nxt = store_conv(i_fmt, regs_r[top_r]);
          tag_nxt[top_r] = NRS_TAG_EMPTY;
          top_nxt = 3'(top_r + 3'h1);
        end
      end
      NRS_OP_WRREL: begin
        regs_nxt[phys] = ld_ext;
        tag_nxt[phys] = classify(ld_ext);
      end
      NRS_OP_RDREL: begin
        if (tag_r[phys] == NRS_TAG_EMPTY) begin
          stack_fault_nxt = 1'b1;
          c1_nxt = 1'b0;
        end else begin
          store_nxt = store_conv(i_fmt, regs_r[phys]);
        end
      end
      NRS_OP_ARITH: begin
        srca_nxt = regs_r[top_r];
        srcb_nxt = i_src_mem ? ld_ext : regs_r[phys];
        if (tag_r[top_r] == NRS_TAG_EMPTY || (!i_src_mem && tag_r[phys] == NRS_TAG_EMPTY)) begin
          stack_fault_nxt = 1'b1;
          c1_nxt = 1'b0;
        end
      end
      NRS_OP_SQRT: begin
        srca_nxt = regs_r[top_r];
        if (tag_r[top_r] == NRS_TAG_EMPTY) begin
          stack_fault_nxt = 1'b1;
          c1_nxt = 1'b0;
        end
      end
      NRS_OP_WRRES: begin
        regs_nxt[phys] = i_res_data;
        tag_nxt[phys] = classify(i_res_data);
      end
      default: begin
        ack_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < NRS_NREG; i++) begin
        regs_r[i] <= 80'h0;
        tag_r[i] <= NRS_TAG_EMPTY;
      end
      top_r <= NRS_TOP_RST;
      stack_fault_r <= 1'b0;
      c1_r <= 1'b0;
      ack_r <= 1'b0;
      store_r <= 80'h0;
      srca_r <= 80'h0;
      srcb_r <= 80'h0;
    end else begin
      regs_r <= regs_nxt;
      tag_r <= tag_nxt;
      top_r <= top_nxt;
      stack_fault_r <= stack_fault_nxt;
      c1_r <= c1_nxt;
      ack_r <= ack_nxt;
      store_r <= store_nxt;
      srca_r <= srca_nxt;
      srcb_r <= srcb_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    o_status_word = 16'h0;
    o_status_word[NRS_SW_TOP_LSB+:3] = top_r;
    o_status_word[NRS_SW_C1_BIT] = c1_r;
    o_status_word[NRS_SW_FAULT_BIT] = stack_fault_r;
    for (int i = 0; i < NRS_NREG; i++) begin
      o_tag_word[2*i+:2] = tag_r[i];
    end
  end
  assign o_store_data = store_r;
  assign o_src_a = srca_r;
  assign o_src_b = srcb_r;
  assign o_ack = ack_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence push_ok_s;
    i_op == NRS_OP_PUSH && tag_r[push_idx] == NRS_TAG_EMPTY;
  endsequence
  sequence pop_ok_s;
    i_op == NRS_OP_POP && tag_r[top_r] != NRS_TAG_EMPTY;
  endsequence

  push_pointer_a: assert property (push_ok_s |=> top_r == 3'($past(top_r) - 3'h1))
    else $error("push did not step top down");
  push_data_a: assert property (push_ok_s |=> regs_r[top_r] == $past(ld_ext))
    else $error("push did not write new top");
  pop_pointer_a: assert property (pop_ok_s |=> top_r == 3'($past(top_r) + 3'h1)
                                  && tag_r[$past(top_r)] == NRS_TAG_EMPTY)
    else $error("pop did not release top");
  top_wrap_a: assert property (push_ok_s and top_r == 3'h0 |=> o_status_word[13:11] == 3'h7)
    else $error("top did not wrap");
  push_pop_a: assert property (push_ok_s ##1 pop_ok_s |=> top_r == $past(top_r, 2))
    else $error("push then pop lost top");
  sqrt_source_a: assert property (i_op == NRS_OP_SQRT |=> o_src_a == regs_r[$past(top_r)])
    else $error("square root source not top");
  rel_write_a: assert property (i_op == NRS_OP_WRREL |=> regs_r[$past(phys)] == $past(ld_ext))
    else $error("relative write went astray");
  overflow_flag_a: assert property (i_op == NRS_OP_PUSH && tag_r[push_idx] != NRS_TAG_EMPTY
                                    |=> o_status_word[6] && o_status_word[9] && $stable(top_r))
    else $error("overflow not flagged");
  single_bias_a: assert property (push_ok_s and i_fmt == NRS_FMT_F32 && i_mem_data[30:23] == 8'h7f
                                  |=> regs_r[top_r][78:64] == 15'h3fff)
    else $error("single bias wrong");

endmodule : nrs_stack

// file: nrs_host_model.sv
`timescale 1ns/1ps
// ****
// Host side: one numeric operation per issue call, two per issue_pair call
// ****
module nrs_host_model import nrs_pkg::*; (
  input wire logic i_mclk,
  output nrs_op_t o_op,
  output nrs_fmt_t o_fmt,
  output logic [2:0] o_idx,
  output logic o_src_mem,
  output logic [79:0] o_mem_data,
  output logic [79:0] o_res_data,
  output logic o_clr_stack_fault
);
  initial begin
    o_op = NRS_OP_NOP;
    o_fmt = NRS_FMT_EXT;
    o_idx = 3'h0;
    o_src_mem = 1'b0;
    o_mem_data = 80'h0;
    o_res_data = 80'h0;
    o_clr_stack_fault = 1'b0;
  end

  task automatic issue(input nrs_op_t op, input nrs_fmt_t fmt, input logic [2:0] idx, input logic srcm,
                       input logic [79:0] data, input logic clr);
    @(posedge i_mclk);
    o_op <= op;
    o_fmt <= fmt;
    o_idx <= idx;
    o_src_mem <= srcm;
    // Operand low-aligned, presented whole from its even start
    o_mem_data <= data;
    o_res_data <= data;
    o_clr_stack_fault <= clr;
    @(posedge i_mclk);
    o_op <= NRS_OP_NOP;
    o_clr_stack_fault <= 1'b0;
    // Released bus shows garbage, not the last operand
    o_mem_data <= ~data;
    o_res_data <= ~data;
    #1;
  endtask : issue

  // Two operations on consecutive edges, no idle cycle between them
  task automatic issue_pair(input nrs_op_t op1, input nrs_op_t op2, input logic [79:0] data);
    @(posedge i_mclk);
    o_op <= op1;
    o_fmt <= NRS_FMT_EXT;
    o_idx <= 3'h0;
    o_src_mem <= 1'b0;
    o_mem_data <= data;
    o_clr_stack_fault <= 1'b0;
    @(posedge i_mclk);
    o_op <= op2;
    @(posedge i_mclk);
    o_op <= NRS_OP_NOP;
    o_mem_data <= ~data;
    #1;
  endtask : issue_pair
endmodule : nrs_host_model

// file: tb_numeric_register_stack.sv
`timescale 1ns/1ps
module tb_numeric_register_stack import nrs_pkg::*; ();
  localparam logic [79:0] ONE = 80'h3fff8000000000000000;
  localparam logic [79:0] VA = 80'h4000c000000000000000;
  localparam logic [79:0] VB = 80'hc0008000000000000000;
  logic i_mclk;
  logic i_rst_n;
  nrs_op_t op;
  nrs_fmt_t fmt;
  logic [2:0] idx;
  logic srcm;
  logic clr;
  logic [79:0] mem;
  logic [79:0] res;
  logic [79:0] st_d;
  logic [79:0] sa;
  logic [79:0] sb;
  logic [15:0] sw;
  logic [15:0] tw;
  logic ack;
  int err_count;
  int comparisons;
  nrs_fmt_t fmts[6] = '{NRS_FMT_I16, NRS_FMT_I32, NRS_FMT_I64, NRS_FMT_F32, NRS_FMT_F64, NRS_FMT_BCD};
  logic [79:0] encs[6] = '{80'h1, 80'h1, 80'h1, 80'h3f800000, 80'h3ff0000000000000, 80'h1};

  nrs_host_model nrs_host_model_i (.i_mclk(i_mclk), .o_op(op), .o_fmt(fmt), .o_idx(idx), .o_src_mem(srcm),
    .o_mem_data(mem), .o_res_data(res), .o_clr_stack_fault(clr));
  nrs_stack nrs_stack_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_op(op), .i_fmt(fmt), .i_idx(idx),
    .i_src_mem(srcm), .i_mem_data(mem), .i_res_data(res), .i_clr_stack_fault(clr), .o_store_data(st_d),
    .o_src_a(sa), .o_src_b(sb), .o_status_word(sw), .o_tag_word(tw), .o_ack(ack));

  // ****
  // Checking and closing
  // ****
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic do_op(input nrs_op_t o, input nrs_fmt_t f, input logic [2:0] x, input logic m,
                       input logic [79:0] d, input logic c);
    nrs_host_model_i.issue(o, f, x, m, d, c);
    chk(ack, o != NRS_OP_NOP);
  endtask : do_op

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    chk(sw, 16'h0000);
    chk(tw, 16'hffff);
  endtask : t_reset

  task automatic t_push();
    do_op(NRS_OP_PUSH, NRS_FMT_EXT, 3'h0, 1'b0, VA, 1'b0);
    chk(sw[13:11], 3'h7);
    chk(tw[15:14], NRS_TAG_VALID);
    do_op(NRS_OP_PUSH, NRS_FMT_EXT, 3'h0, 1'b0, VB, 1'b0);
    chk(sw[13:11], 3'h6);
    chk(tw, 16'h0fff);
  endtask : t_push

  task automatic t_access();
    do_op(NRS_OP_RDREL, NRS_FMT_EXT, 3'h1, 1'b0, 80'h0, 1'b0);
    chk(st_d, VA);
    do_op(NRS_OP_SQRT, NRS_FMT_EXT, 3'h1, 1'b1, 80'h0, 1'b0);
    chk(sa, VB);
    do_op(NRS_OP_ARITH, NRS_FMT_EXT, 3'h1, 1'b0, 80'h0, 1'b0);
    chk(sb, VA);
    do_op(NRS_OP_ARITH, NRS_FMT_I16, 3'h1, 1'b1, 80'h1, 1'b0);
    chk(sa, VB);
    chk(sb, ONE);
    do_op(NRS_OP_SQRT, NRS_FMT_EXT, 3'h0, 1'b0, 80'h0, 1'b0);
    chk(sb, ONE);
    chk(sa, VB);
  endtask : t_access

  task automatic t_tags();
    do_op(NRS_OP_WRRES, NRS_FMT_EXT, 3'h1, 1'b0, 80'h0, 1'b0);
    chk(tw[15:14], NRS_TAG_ZERO);
    do_op(NRS_OP_WRRES, NRS_FMT_EXT, 3'h1, 1'b0, 80'h7fffc000000000000000, 1'b0);
    chk(tw[15:14], NRS_TAG_SPECIAL);
    do_op(NRS_OP_WRREL, NRS_FMT_I16, 3'h1, 1'b0, 80'h1, 1'b0);
    chk(tw[15:14], NRS_TAG_VALID);
    do_op(NRS_OP_RDREL, NRS_FMT_EXT, 3'h1, 1'b0, 80'h0, 1'b0);
    chk(st_d, ONE);
    do_op(NRS_OP_WRRES, NRS_FMT_EXT, 3'h1, 1'b0, VA, 1'b0);
    chk(tw[15:14], NRS_TAG_VALID);
  endtask : t_tags

  task automatic t_pop();
    do_op(NRS_OP_POP, NRS_FMT_EXT, 3'h0, 1'b0, 80'h0, 1'b0);
    chk(st_d, VB);
    chk(sw[13:11], 3'h7);
    chk(tw, 16'h3fff);
    do_op(NRS_OP_POP, NRS_FMT_EXT, 3'h0, 1'b0, 80'h0, 1'b0);
    chk(st_d, VA);
    chk(sw, 16'h0000);
  endtask : t_pop

  // Push and pop on back-to-back edges
  task automatic t_b2b();
    nrs_host_model_i.issue_pair(NRS_OP_PUSH, NRS_OP_POP, VB);
    chk(ack, 80'h1);
    chk(st_d, VB);
    chk(sw, 16'h0000);
    chk(tw, 16'hffff);
  endtask : t_b2b

  // Reset in mid-run clears store data, ack, status word and tag word
  task automatic t_rerst();
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    #1;
    chk(st_d, 80'h0);
    chk(ack, 80'h0);
    chk(sw, 16'h0000);
    chk(tw, 16'hffff);
  endtask : t_rerst

  // Every memory format except NRS_FMT_EXT round-trips the value one
  task automatic t_formats();
    for (int i = 0; i < 6; i++) begin
      do_op(NRS_OP_PUSH, fmts[i], 3'h0, 1'b0, encs[i], 1'b0);
      do_op(NRS_OP_POP, NRS_FMT_EXT, 3'h0, 1'b0, 80'h0, 1'b0);
      chk(st_d, ONE);
      do_op(NRS_OP_PUSH, NRS_FMT_EXT, 3'h0, 1'b0, ONE, 1'b0);
      do_op(NRS_OP_POP, fmts[i], 3'h0, 1'b0, 80'h0, 1'b0);
      chk(st_d, encs[i]);
    end
  endtask : t_formats

  task automatic t_fault();
    do_op(NRS_OP_POP, NRS_FMT_EXT, 3'h0, 1'b0, 80'h0, 1'b0);
    chk(sw, 16'h0040);
    do_op(NRS_OP_NOP, NRS_FMT_EXT, 3'h0, 1'b0, 80'h0, 1'b1);
    chk(sw, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      do_op(NRS_OP_PUSH, NRS_FMT_EXT, 3'h0, 1'b0, VA, 1'b0);
    end
    chk(tw, 16'h0000);
    do_op(NRS_OP_PUSH, NRS_FMT_EXT, 3'h0, 1'b0, VB, 1'b0);
    chk(sw, 16'h0240);
    do_op(NRS_OP_PUSH, NRS_FMT_EXT, 3'h0, 1'b0, VB, 1'b1);
    chk(sw, 16'h0240);
    do_op(NRS_OP_RDREL, NRS_FMT_EXT, 3'h7, 1'b0, 80'h0, 1'b0);
    chk(st_d, VA);
  endtask : t_fault

  // ****
  // Clock, reset, sequence, watchdog
  // ****
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  initial begin
    err_count = 0;
    comparisons = 0;
    i_rst_n = 1'b0;
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    #1;
    t_reset();
    t_push();
    t_access();
    t_tags();
    t_pop();
    t_b2b();
    t_formats();
    t_fault();
    t_rerst();
    test_done();
  end

  // Run needs well under 200 cycles
  initial begin
    #20000;
    err_count++;
    test_done();
  end
endmodule : tb_numeric_register_stack
